// File: shared/mic_pkg.sv
/*
 * Shared constants and types of the maskable interrupt control block.
 * Assumes a CPU sequencer on the same clock and an APB master on pclk.
 */
package mic_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_PRIO = 8'h08;
	localparam logic [7:0] ADDR_OPTION = 8'h0c;
	localparam logic [7:0] ADDR_STATE = 8'h10;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int PRIO_EN_BIT = 8;
	localparam int OPT_EDGE_BIT = 0;
	localparam int OPT_LOCK_BIT = 1;
	localparam int OPT_MASK_BIT = 8;
	localparam int STATE_BUSY_BIT = 8;
	localparam int CC_MASK_BIT = 4;
	localparam logic RST_MASK = 1'b1;
	localparam logic RST_EDGE_SEL = 1'b0;
	// Time-protected write window, in E-clock cycles
	localparam int EDGE_WINDOW_CYC = 64;
	// ----------------------------------------
	// Stack slots, in push order
	// ----------------------------------------
	localparam logic [3:0] SLOT_PC_LO = 4'h0;
	localparam logic [3:0] SLOT_PC_HI = 4'h1;
	localparam logic [3:0] SLOT_Y_LO = 4'h2;
	localparam logic [3:0] SLOT_Y_HI = 4'h3;
	localparam logic [3:0] SLOT_X_LO = 4'h4;
	localparam logic [3:0] SLOT_X_HI = 4'h5;
	localparam logic [3:0] SLOT_ACA = 4'h6;
	localparam logic [3:0] SLOT_ACB = 4'h7;
	localparam logic [3:0] SLOT_CC = 4'h8;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] y;
		logic [15:0] x;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] cc;
	} mic_cpu_regs_t;

	typedef enum logic [1:0] {
		MIC_IDLE,
		MIC_PUSH,
		MIC_VEC,
		MIC_PULL
	} mic_state_t;

	function automatic logic [7:0] mic_stack_byte(input mic_cpu_regs_t r, input logic [3:0] s);
		case (s)
			SLOT_PC_LO: return r.pc[7:0];
			SLOT_PC_HI: return r.pc[15:8];
			SLOT_Y_LO: return r.y[7:0];
			SLOT_Y_HI: return r.y[15:8];
			SLOT_X_LO: return r.x[7:0];
			SLOT_X_HI: return r.x[15:8];
			SLOT_ACA: return r.a;
			SLOT_ACB: return r.b;
			default: return r.cc;
		endcase
	endfunction
endpackage

// File: rtl/mic_ctrl.sv
/*
 * Maskable interrupt control: global mask bit, priority select,
 * stacking and unstacking sequence, external request pin and
 * internal request flags, with an APB register slave.
 * Assumes the CPU sequencer shares pclk (the E clock) and that
 * the request pin is asynchronous to it.
 */
`timescale 1ns/100ps
module mic_ctrl #(
	parameter int NSRC = 20
) (
	input wire logic pclk, // E clock
	input wire logic presetn, // async reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic irq_n_pin, // external request pin
	input wire logic [NSRC-2:0] periph_event, // internal event pulses
	input wire logic instr_boundary, // instruction finishing
	input wire logic set_mask_instr, // set-mask executing
	input wire logic clear_mask_instr, // clear-mask executing
	input wire logic cc_load, // transfer to codes
	input wire logic [7:0] cc_load_data, // value transferred
	input wire logic return_from_service_instr, // start unstack
	input wire mic_pkg::mic_cpu_regs_t cpu_regs, // live registers
	output logic stack_wr, // push request
	output logic [7:0] stack_byte, // byte to push
	input wire logic stack_ack, // push done
	output logic unstack_rd, // pull request
	input wire logic [7:0] unstack_byte, // pulled byte
	input wire logic unstack_ack, // pull done
	output mic_pkg::mic_cpu_regs_t restored, // reloaded registers
	output logic restore_done, // unstack complete
	output logic vector_req, // vector fetch request
	output logic [4:0] vector_src, // source to vector
	input wire logic vector_ack, // vector fetched
	output logic seq_busy, // sequencer stalled
	output logic mask_bit, // global mask
	output logic int_out // unmasked source pending
);
	import mic_pkg::*;

	localparam int SW = 5;
	localparam logic [6:0] WIN_CNT = 7'(EDGE_WINDOW_CYC);

	mic_state_t st;
	logic [3:0] idx;
	logic clr_pend;
	logic pin_m, pin_s, pin_d;
	logic edge_sel, edge_lock, edge_pend;
	logic [6:0] win_cnt;
	logic [NSRC-1:1] flags;
	logic [NSRC-1:0] enable;
	logic [SW-1:0] prom_idx;
	logic prom_en;
	logic [SW-1:0] taken_src;
	mic_cpu_regs_t snap;
	logic ext_req, pin_fall;
	logic [NSRC-1:0] status_view, req_vec;
	logic any_req, take, set_any, clr_any;
	logic eff_mask, ret_go, push_last, pull_cc, pull_last;
	logic wr_en, rd_setup;
	logic [SW-1:0] sel;
	logic [3:0] pull_slot;

	// ----------------------------------------
	// External pin
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_m <= 1'b1;
			pin_s <= 1'b1;
			pin_d <= 1'b1;
		end else begin
			pin_m <= irq_n_pin;
			pin_s <= pin_m;
			pin_d <= pin_s;
		end
	end

	assign pin_fall = pin_d && !pin_s;

	// Edge latch: a new edge wins over the clear by vector fetch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_pend <= 1'b0;
		end else if (edge_sel && pin_fall) begin
			edge_pend <= 1'b1;
		end else if (vector_req && vector_ack && vector_src == '0) begin
			edge_pend <= 1'b0;
		end
	end

	// Level mode relies on the outside holding the pin low until served
	assign ext_req = edge_sel ? edge_pend : !pin_s;

	// ----------------------------------------
	// Time-protected edge select
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt <= '0;
		end else if (win_cnt != WIN_CNT) begin
			win_cnt <= win_cnt + 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_sel <= RST_EDGE_SEL;
			edge_lock <= 1'b0;
		end else if (wr_en && paddr == ADDR_OPTION && !edge_lock && win_cnt != WIN_CNT) begin
			edge_sel <= pwdata[OPT_EDGE_BIT];
			edge_lock <= 1'b1;
		end
	end

	// ----------------------------------------
	// Internal flags and requests
	// ----------------------------------------
	// Event set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else if (wr_en && paddr == ADDR_STATUS) begin
			flags <= (flags & ~pwdata[NSRC-1:1]) | periph_event;
		end else begin
			flags <= flags | periph_event;
		end
	end

	assign status_view = {flags, ext_req};
	// Pin needs no local enable
	assign req_vec = status_view & {enable[NSRC-1:1], 1'b1};
	assign any_req = |req_vec;
	assign int_out = any_req && !mask_bit;

	always_comb begin
		sel = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req_vec[i]) begin
				sel = SW'(i);
			end
		end
		if (prom_en && prom_idx < SW'(NSRC) && req_vec[prom_idx]) begin
			sel = prom_idx;
		end
	end

	// ----------------------------------------
	// Global mask
	// ----------------------------------------
	assign push_last = st == MIC_PUSH && stack_ack && idx == SLOT_CC;
	assign pull_cc = st == MIC_PULL && unstack_ack && idx == '0;
	assign pull_last = st == MIC_PULL && unstack_ack && idx == SLOT_CC;
	assign set_any = set_mask_instr || (cc_load && cc_load_data[CC_MASK_BIT])
		|| push_last || (pull_cc && unstack_byte[CC_MASK_BIT]);
	assign clr_any = clear_mask_instr || (cc_load && !cc_load_data[CC_MASK_BIT])
		|| (pull_cc && !unstack_byte[CC_MASK_BIT]);
	// Set acts in the same cycle, so nothing slips past it
	assign eff_mask = mask_bit || set_mask_instr || (cc_load && cc_load_data[CC_MASK_BIT]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_bit <= RST_MASK;
			clr_pend <= 1'b0;
		end else if (set_any) begin
			mask_bit <= 1'b1;
			clr_pend <= 1'b0;
		end else if (clr_any) begin
			clr_pend <= 1'b1;
			// A clear already waiting still expires on time
			if (clr_pend) begin
				mask_bit <= 1'b0;
			end
		end else if (clr_pend) begin
			mask_bit <= 1'b0;
			clr_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// Response sequence
	// ----------------------------------------
	assign take = st == MIC_IDLE && instr_boundary && !eff_mask && any_req;
	assign ret_go = st == MIC_IDLE && !take && return_from_service_instr;
	assign pull_slot = SLOT_CC - idx;
	assign seq_busy = st != MIC_IDLE;
	assign stack_wr = st == MIC_PUSH;
	assign unstack_rd = st == MIC_PULL;
	assign vector_req = st == MIC_VEC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= MIC_IDLE;
			idx <= '0;
		end else begin
			case (st)
				MIC_IDLE: begin
					idx <= '0;
					if (take) begin
						st <= MIC_PUSH;
					end else if (ret_go) begin
						st <= MIC_PULL;
					end
				end
				MIC_PUSH: begin
					if (stack_ack) begin
						idx <= idx + 4'h1;
						if (idx == SLOT_CC) begin
							st <= MIC_VEC;
						end
					end
				end
				MIC_VEC: begin
					if (vector_ack) begin
						st <= MIC_IDLE;
					end
				end
				default: begin
					if (unstack_ack) begin
						idx <= idx + 4'h1;
						if (idx == SLOT_CC) begin
							st <= MIC_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Registers frozen at entry; stacked mask copy is the live one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap <= '0;
			stack_byte <= '0;
			taken_src <= '0;
		end else if (take) begin
			snap <= cpu_regs;
			snap.cc[CC_MASK_BIT] <= mask_bit;
			stack_byte <= mic_stack_byte(cpu_regs, SLOT_PC_LO);
			taken_src <= sel;
		end else if (st == MIC_PUSH && stack_ack && idx != SLOT_CC) begin
			stack_byte <= mic_stack_byte(snap, idx + 4'h1);
		end
	end

	// Vector picked after the stacking; the entry pick taken_src is kept if no request remains
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_src <= '0;
		end else if (push_last) begin
			vector_src <= any_req ? sel : taken_src;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restored <= '0;
			restore_done <= 1'b0;
		end else begin
			restore_done <= pull_last;
			if (st == MIC_PULL && unstack_ack) begin
				case (pull_slot)
					SLOT_PC_LO: restored.pc[7:0] <= unstack_byte;
					SLOT_PC_HI: restored.pc[15:8] <= unstack_byte;
					SLOT_Y_LO: restored.y[7:0] <= unstack_byte;
					SLOT_Y_HI: restored.y[15:8] <= unstack_byte;
					SLOT_X_LO: restored.x[7:0] <= unstack_byte;
					SLOT_X_HI: restored.x[15:8] <= unstack_byte;
					SLOT_ACA: restored.a <= unstack_byte;
					SLOT_ACB: restored.b <= unstack_byte;
					default: restored.cc <= unstack_byte;
				endcase
			end
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states: read data is fetched in the setup cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= '0;
			prom_idx <= '0;
			prom_en <= 1'b0;
		end else if (wr_en && paddr == ADDR_ENABLE) begin
			enable <= pwdata[NSRC-1:0];
		end else if (wr_en && paddr == ADDR_PRIO) begin
			prom_idx <= pwdata[SW-1:0];
			prom_en <= pwdata[PRIO_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata <= '0;
			pslverr <= 1'b0;
			if (paddr == ADDR_STATUS) begin
				prdata[NSRC-1:0] <= status_view;
			end else if (paddr == ADDR_ENABLE) begin
				prdata[NSRC-1:0] <= enable;
			end else if (paddr == ADDR_PRIO) begin
				prdata[SW-1:0] <= prom_idx;
				prdata[PRIO_EN_BIT] <= prom_en;
			end else if (paddr == ADDR_OPTION) begin
				prdata[OPT_EDGE_BIT] <= edge_sel;
				prdata[OPT_LOCK_BIT] <= edge_lock || win_cnt == WIN_CNT;
				prdata[OPT_MASK_BIT] <= mask_bit;
			end else if (paddr == ADDR_STATE) begin
				prdata[SW-1:0] <= vector_src;
				prdata[STATE_BUSY_BIT] <= seq_busy;
			end else begin
				pslverr <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence push_first_s;
		stack_wr && idx == SLOT_PC_LO && stack_byte == $past(cpu_regs.pc[7:0]);
	endsequence
	sequence pull_first_s;
		unstack_rd && pull_slot == SLOT_CC;
	endsequence
	sequence vec_after_push_s;
		mask_bit && vector_req;
	endsequence

	mask_gate_a: assert property (take |-> !mask_bit && enable[sel] | sel == '0) else $error("take while masked");
	boundary_a: assert property ((!instr_boundary && !seq_busy) |=> !stack_wr) else $error("take off boundary");
	set_now_a: assert property ((set_mask_instr && !seq_busy) |=> !stack_wr && mask_bit)
		else $error("take beside set-mask");
	clear_late_a: assert property ((clear_mask_instr && mask_bit && !set_any) |=>
		mask_bit ##1 (!mask_bit || $past(set_any))) else $error("mask clear timing");
	push_start_a: assert property (take |=> push_first_s) else $error("push order start");
	vec_order_a: assert property (push_last |=> vec_after_push_s) else $error("vector before mask");
	pull_start_a: assert property (ret_go |=> pull_first_s) else $error("pull not codes first");
	edge_lock_a: assert property ((wr_en && paddr == ADDR_OPTION && win_cnt == WIN_CNT) |=> $stable(edge_sel))
		else $error("late edge select write");
	edge_latch_a: assert property ((edge_sel && pin_fall) |=> edge_pend) else $error("edge not latched");
	flag_hold_a: assert property ((flags[1] && !(wr_en && paddr == ADDR_STATUS)) |=> flags[1])
		else $error("flag lost");
	reset_mask_a: assert property ($rose(presetn) |-> mask_bit && !edge_sel) else $error("reset state");
endmodule

// File: verif/mic_irq_src.sv
/*
 * Far-side model: outside request sources sharing the wired-OR request pin.
 * Assumes a pull-up on the pin and that each source holds the pin low until it is served.
 */
`timescale 1ns/100ps
module mic_irq_src #(
	parameter int N = 2
) (
	input wire logic [N-1:0] pull, // per-source request
	output logic irq_n_pin // shared pin
);
	// Open drain: any source pulls low, the pull-up wins otherwise
	assign irq_n_pin = ~|pull;
endmodule

// File: verif/mic_ctrl_tb.sv
/*
 * Self-checking bench for mic_ctrl: table of priority cases, then mask timing,
 * return sequence and edge-mode pin.
 * Assumes zero-wait APB answers and the pin driven by mic_irq_src.
 */
`timescale 1ns/100ps
module mic_ctrl_tb;
	import mic_pkg::*;
	typedef struct packed {
		logic [19:0] en;
		logic [19:0] ev;
		logic [8:0] prio;
		logic [4:0] src;
	} mic_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [18:0] periph_event = '0;
	logic instr_boundary = 1'b0;
	logic set_mask_instr = 1'b0;
	logic clear_mask_instr = 1'b0;
	logic return_from_service_instr = 1'b0;
	logic stack_ack = 1'b0;
	logic unstack_ack = 1'b0;
	logic vector_ack = 1'b0;
	logic cc_load = 1'b0;
	logic [7:0] cc_load_data = 8'h00;
	logic [7:0] unstack_byte = 8'h00;
	logic [1:0] pull = 2'b00;
	mic_cpu_regs_t cpu_regs = {16'h1234, 16'h5678, 16'h9abc, 8'hde, 8'hf0, 8'hc0};
	mic_cpu_regs_t ret_regs = {16'h4321, 16'h8765, 16'hcba9, 8'h5a, 8'ha5, 8'hc0};
	mic_cpu_regs_t restored;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready, pslverr, irq_n_pin, stack_wr, unstack_rd, restore_done, vector_req, seq_busy, mask_bit, int_out, e;
	logic [7:0] stack_byte;
	logic [4:0] vector_src;
	int n_fail = 0;
	int total_checks = 0;
	mic_row_t rows [5] = '{
		'{20'h00088, 20'h00088, 9'h000, 5'd3},
		'{20'h81020, 20'h81020, 9'h10c, 5'd12},
		'{20'h80004, 20'h80004, 9'h113, 5'd19},
		'{20'h00010, 20'h00014, 9'h000, 5'd4},
		'{20'h00002, 20'h00003, 9'h000, 5'd0}};

	always #10 pclk = ~pclk;

	mic_ctrl #(.NSRC(20)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq_n_pin, .periph_event, .instr_boundary, .set_mask_instr, .clear_mask_instr,
		.cc_load, .cc_load_data, .return_from_service_instr, .cpu_regs, .stack_wr, .stack_byte,
		.stack_ack, .unstack_rd, .unstack_byte, .unstack_ack, .restored, .restore_done, .vector_req,
		.vector_src, .vector_ack, .seq_busy, .mask_bit, .int_out);
	mic_irq_src #(.N(2)) u_src (.pull, .irq_n_pin);

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
		output logic re);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait in which ready never comes
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
		apb(1'b0, a, 32'h0, q, e);
		chk({e, q & m}, {1'b0, exp}, what);
	endtask

	task automatic reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(mask_bit, 1'b1, "reset mask");
	endtask

	task automatic pulse(input logic [19:0] v);
		@(posedge pclk);
		periph_event <= v[19:1];
		pull[0] <= v[0];
		@(posedge pclk);
		periph_event <= '0;
	endtask

	task automatic pin(input logic v);
		@(posedge pclk);
		pull[0] <= v;
		repeat (4) @(posedge pclk);
	endtask

	task automatic clr_mask();
		@(posedge pclk);
		clear_mask_instr <= 1'b1;
		@(posedge pclk);
		clear_mask_instr <= 1'b0;
		@(negedge pclk);
		chk(mask_bit, 1'b1, "clear delayed");
		@(negedge pclk);
		chk(mask_bit, 1'b0, "clear done");
	endtask

	task automatic take(input logic [4:0] src);
		logic [7:0] b [9];
		b = '{cpu_regs.pc[7:0], cpu_regs.pc[15:8], cpu_regs.y[7:0], cpu_regs.y[15:8], cpu_regs.x[7:0],
			cpu_regs.x[15:8], cpu_regs.a, cpu_regs.b, cpu_regs.cc};
		repeat (3) @(negedge pclk);
		chk(stack_wr, 1'b0, "no take between instructions");
		@(posedge pclk);
		instr_boundary <= 1'b1;
		@(posedge pclk);
		instr_boundary <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			@(negedge pclk);
			chk({stack_wr, stack_byte}, {1'b1, b[i]}, "push byte");
			@(posedge pclk);
			stack_ack <= 1'b1;
			@(posedge pclk);
			stack_ack <= 1'b0;
		end
		@(negedge pclk);
		chk({vector_req, mask_bit, vector_src}, {2'b11, src}, "vector");
		@(posedge pclk);
		vector_ack <= 1'b1;
		@(posedge pclk);
		vector_ack <= 1'b0;
	endtask

	task automatic ret(input mic_cpu_regs_t r);
		logic [7:0] b [9];
		b = '{r.cc, r.b, r.a, r.x[15:8], r.x[7:0], r.y[15:8], r.y[7:0], r.pc[15:8], r.pc[7:0]};
		@(posedge pclk);
		return_from_service_instr <= 1'b1;
		@(posedge pclk);
		return_from_service_instr <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			@(negedge pclk);
			chk({unstack_rd, seq_busy}, 2'b11, "pull request");
			if (i == 2) chk(mask_bit, 1'b0, "mask cleared mid-return");
			@(posedge pclk);
			unstack_ack <= 1'b1;
			unstack_byte <= b[i];
			@(posedge pclk);
			unstack_ack <= 1'b0;
			unstack_byte <= ~b[i];
		end
		@(negedge pclk);
		chk({restore_done, seq_busy, restored}, {2'b10, r}, "restored");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------
	// Tests
	// ------------------------------
	initial begin
		repeat (8000) @(posedge pclk);
		n_fail++;
		$display("BAD t=%0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		reset();
		rdchk(ADDR_OPTION, 32'h100, 32'h101, "option reset");
		apb(1'b0, 8'h20, 32'h0, q, e);
		chk({e, q}, {1'b1, 32'h0}, "unmapped read");
		$display("test reset done");
		foreach (rows[k]) begin
			wr(ADDR_ENABLE, {12'h0, rows[k].en});
			wr(ADDR_PRIO, {23'h0, rows[k].prio});
			pulse(rows[k].ev);
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			chk(int_out, 1'b0, "held while masked");
			rdchk(ADDR_STATUS, {12'h0, rows[k].ev}, 32'hfffff, "flags");
			clr_mask();
			chk(int_out, 1'b1, "request after clear");
			take(rows[k].src);
			pull[0] <= 1'b0;
			wr(ADDR_STATUS, 32'hffff_fffe);
			rdchk(ADDR_STATUS, 32'h0, 32'hfffff, "flags cleared");
			$display("test row %0d done", k);
		end
		wr(ADDR_ENABLE, 32'h4);
		pulse(20'h4);
		clr_mask();
		@(posedge pclk);
		set_mask_instr <= 1'b1;
		instr_boundary <= 1'b1;
		@(posedge pclk);
		set_mask_instr <= 1'b0;
		instr_boundary <= 1'b0;
		@(negedge pclk);
		chk({stack_wr, mask_bit, int_out}, 3'b010, "set blocks at once");
		@(posedge pclk);
		cc_load <= 1'b1;
		cc_load_data <= 8'h00;
		@(posedge pclk);
		cc_load <= 1'b0;
		@(negedge pclk);
		chk(mask_bit, 1'b1, "code clear delayed");
		@(negedge pclk);
		chk(mask_bit, 1'b0, "code clear done");
		@(posedge pclk);
		cc_load <= 1'b1;
		cc_load_data <= 8'h10;
		instr_boundary <= 1'b1;
		@(posedge pclk);
		cc_load <= 1'b0;
		instr_boundary <= 1'b0;
		@(negedge pclk);
		chk({stack_wr, mask_bit}, 2'b01, "code set blocks at once");
		clr_mask();
		take(5'd2);
		rdchk(ADDR_STATE, 32'h2, 32'h11f, "state after take");
		ret(ret_regs);
		wr(ADDR_STATUS, 32'hffff_fffe);
		wr(ADDR_OPTION, 32'h1);
		rdchk(ADDR_OPTION, 32'h0, 32'h1, "late write ignored");
		pull[1] <= 1'b1;
		repeat (3) @(posedge pclk);
		rdchk(ADDR_STATUS, 32'h1, 32'hfffff, "second source on pin");
		pull[1] <= 1'b0;
		$display("test mask and return done");
		reset();
		wr(ADDR_OPTION, 32'h1);
		wr(ADDR_OPTION, 32'h0);
		rdchk(ADDR_OPTION, 32'h101, 32'h101, "edge select once");
		clr_mask();
		pin(1'b1);
		chk(int_out, 1'b1, "edge latched");
		take(5'd0);
		clr_mask();
		chk(int_out, 1'b0, "low level ignored after fetch");
		pin(1'b0);
		pin(1'b1);
		chk(int_out, 1'b1, "new edge");
		pin(1'b0);
		$display("test edge mode done");
		tally_and_finish();
	end
endmodule
